// file: caf_pkg.sv
// Package of register map, field layout and reset values for the acceptance filter router
`default_nettype none
package caf_pkg;
    localparam int CAF_NUM_FILTERS = 16;
    localparam int CAF_NUM_MASKS = 3;
    localparam int CAF_ADDR_W = 8;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CAF_OFF_DEST0 = 8'h00;
    localparam logic [7:0] CAF_OFF_DEST3 = 8'h0C;
    localparam logic [7:0] CAF_OFF_MSEL1 = 8'h10;
    localparam logic [7:0] CAF_OFF_MSEL2 = 8'h14;
    localparam logic [7:0] CAF_OFF_FEN = 8'h18;
    localparam logic [7:0] CAF_OFF_MSID0 = 8'h20;
    localparam logic [7:0] CAF_OFF_MEID0 = 8'h30;
    localparam logic [7:0] CAF_OFF_FILT0 = 8'h40;
    localparam logic [7:0] CAF_OFF_FILT_LAST = 8'hBC;
    localparam logic [7:0] CAF_OFF_STATUS = 8'hC0;
    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int CAF_SID_LSB = 5;
    localparam int CAF_TYPE_BIT = 3;
    localparam int CAF_DEST_W = 4;
    localparam int CAF_MSEL_W = 2;
    localparam logic [15:0] CAF_SID_WMASK = 16'hFFEB;
    localparam logic [3:0] CAF_DEST_FIFO = 4'hF;
    localparam logic [1:0] CAF_MSEL_NONE = 2'h3;
    // ----------------------------------------------------------------
    // Reset values and bus answers
    // ----------------------------------------------------------------
    localparam logic [15:0] CAF_RST_DEST = 16'h0000;
    localparam logic [15:0] CAF_RST_MSEL = 16'h0000;
    localparam logic [15:0] CAF_RST_FEN = 16'hFFFF;
    localparam logic [15:0] CAF_RST_ID = 16'h0000;
    localparam logic [1:0] CAF_RESP_OKAY = 2'h0;
    localparam logic [1:0] CAF_RESP_SLVERR = 2'h2;
endpackage : caf_pkg
`default_nettype wire

// file: caf_filter_match.sv
// One acceptance filter comparator against the selected mask
`default_nettype none
module caf_filter_match
    import caf_pkg::*;
(
    input wire logic enable,
    input wire logic [15:0] filt_sid,
    input wire logic [15:0] filt_eid,
    input wire logic [15:0] mask_sid,
    input wire logic [15:0] mask_eid,
    input wire logic [10:0] msg_sid,
    input wire logic [17:0] msg_eid,
    input wire logic msg_ext,
    output logic hit
);
    logic sid_ok;
    logic eid_ok;
    logic type_ok;

    always_comb begin
        // Cleared mask bits are don't care
        sid_ok = ((filt_sid[15:CAF_SID_LSB] ^ msg_sid) & mask_sid[15:CAF_SID_LSB]) == 11'h000;
        eid_ok = (({filt_sid[1:0], filt_eid} ^ msg_eid) & {mask_sid[1:0], mask_eid}) == 18'h00000;
        // Qualifier clear lets either frame type through
        type_ok = !mask_sid[CAF_TYPE_BIT] || (filt_sid[CAF_TYPE_BIT] == msg_ext);
        // Standard frames carry no extended bits, so only the SID is compared
        hit = enable && type_ok && sid_ok && (!msg_ext || eid_ok);
    end
endmodule : caf_filter_match
`default_nettype wire

// file: caf_router.sv
// Acceptance filter router with AXI4-Lite register slave
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`default_nettype none
// Summary of operation
// - A destination field of all ones sends the accepted message to the receive FIFO.
// - Destination values 0 to 14 send the accepted message to the receive buffer of that index.
// - Four destination fields pack into each of four registers, highest filter in bits 15-12.
// - Sixteen filters exist, each with its own standard and extended identifier register.
// - The filter's 11-bit standard identifier in bits 15-5 must equal the message's for a match.
// - The 18-bit extended identifier, upper bits in SID bits 1-0, must equal the message's for an extended-frame match.
// - With the qualifier set, the frame-type bit picks extended (1) or standard (0) frames only.
// - Bits 4 and 2 of each filter standard-identifier register read as zero.
// - A 2-bit selector applies mask 0, 1 or 2, or with value 11 no mask at all.
// - Selectors of filters 0-7 pack two bits each, filter 7 in bits 15-14.
// - A mask bit of one includes the identifier bit, zero makes it don't care.
// - The mask's qualifier at bit 3, when clear, lets both frame types match.
// - Only enabled filters may match.
module caf_router
    import caf_pkg::*;
#(
    parameter int NUM_FILTERS = CAF_NUM_FILTERS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [CAF_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [CAF_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic msg_valid,
    input wire logic [10:0] msg_sid,
    input wire logic [17:0] msg_eid,
    input wire logic msg_ext,
    output logic acc_valid,
    output logic acc_to_fifo,
    output logic [3:0] acc_buffer,
    output logic [3:0] acc_filter,
    output logic rej_valid
);
    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [15:0] dest [4], next_dest [4];
    logic [15:0] msel [2], next_msel [2];
    logic [15:0] fen, next_fen;
    logic [15:0] msk_sid [CAF_NUM_MASKS], next_msk_sid [CAF_NUM_MASKS];
    logic [15:0] msk_eid [CAF_NUM_MASKS], next_msk_eid [CAF_NUM_MASKS];
    logic [15:0] f_sid [NUM_FILTERS], next_f_sid [NUM_FILTERS];
    logic [15:0] f_eid [NUM_FILTERS], next_f_eid [NUM_FILTERS];
    logic [15:0] status, next_status;

    // ----------------------------------------------------------------
    // AXI4-Lite channel state
    // ----------------------------------------------------------------
    logic aw_full, next_aw_full;
    logic w_full, next_w_full;
    logic [CAF_ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    function automatic logic [15:0] caf_merge(input logic [15:0] old, input logic [31:0] data,
                                              input logic [3:0] strb, input logic [15:0] wmask);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res & wmask;
    endfunction : caf_merge

    // Read decode returns data and a hit flag
    function automatic logic [16:0] caf_read(input logic [CAF_ADDR_W-1:0] a);
        logic [16:0] r;
        logic [7:0] fi;
        r = 17'h00000;
        fi = 8'((a - CAF_OFF_FILT0) >> 3);
        if (a[1:0] != 2'h0) begin
            r = 17'h00000;
        end else if (a <= CAF_OFF_DEST3) begin
            r = {1'b1, dest[a[3:2]]};
        end else if (a == CAF_OFF_MSEL1 || a == CAF_OFF_MSEL2) begin
            r = {1'b1, msel[a[2]]};
        end else if (a == CAF_OFF_FEN) begin
            r = {1'b1, fen};
        end else if (a >= CAF_OFF_MSID0 && a < CAF_OFF_MSID0 + 8'h0C) begin
            r = {1'b1, msk_sid[2'((a - CAF_OFF_MSID0) >> 2)]};
        end else if (a >= CAF_OFF_MEID0 && a < CAF_OFF_MEID0 + 8'h0C) begin
            r = {1'b1, msk_eid[2'((a - CAF_OFF_MEID0) >> 2)]};
        end else if (a >= CAF_OFF_FILT0 && a <= CAF_OFF_FILT_LAST) begin
            r = a[2] ? {1'b1, f_eid[fi[3:0]]} : {1'b1, f_sid[fi[3:0]]};
        end else if (a == CAF_OFF_STATUS) begin
            r = {1'b1, status};
        end
        return r;
    endfunction : caf_read

    // ----------------------------------------------------------------
    // Bus and register next-state
    // ----------------------------------------------------------------
    always_comb begin
        logic [7:0] fi;
        logic hit;
        logic [16:0] rd;
        fi = 8'h00;
        hit = 1'b0;
        rd = 17'h00000;
        next_dest = dest;
        next_msel = msel;
        next_fen = fen;
        next_msk_sid = msk_sid;
        next_msk_eid = msk_eid;
        next_f_sid = f_sid;
        next_f_eid = f_eid;
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // Both halves held: commit the write and answer
        if (aw_full && w_full && !s_axi_bvalid) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            hit = 1'b1;
            fi = 8'((aw_addr - CAF_OFF_FILT0) >> 3);
            if (aw_addr[1:0] != 2'h0) begin
                hit = 1'b0;
            end else if (aw_addr <= CAF_OFF_DEST3) begin
                next_dest[aw_addr[3:2]] = caf_merge(dest[aw_addr[3:2]], w_data, w_strb, 16'hFFFF);
            end else if (aw_addr == CAF_OFF_MSEL1 || aw_addr == CAF_OFF_MSEL2) begin
                next_msel[aw_addr[2]] = caf_merge(msel[aw_addr[2]], w_data, w_strb, 16'hFFFF);
            end else if (aw_addr == CAF_OFF_FEN) begin
                next_fen = caf_merge(fen, w_data, w_strb, 16'hFFFF);
            end else if (aw_addr >= CAF_OFF_MSID0 && aw_addr < CAF_OFF_MSID0 + 8'h0C) begin
                next_msk_sid[2'((aw_addr - CAF_OFF_MSID0) >> 2)] =
                    caf_merge(msk_sid[2'((aw_addr - CAF_OFF_MSID0) >> 2)], w_data, w_strb, CAF_SID_WMASK);
            end else if (aw_addr >= CAF_OFF_MEID0 && aw_addr < CAF_OFF_MEID0 + 8'h0C) begin
                next_msk_eid[2'((aw_addr - CAF_OFF_MEID0) >> 2)] =
                    caf_merge(msk_eid[2'((aw_addr - CAF_OFF_MEID0) >> 2)], w_data, w_strb, 16'hFFFF);
            end else if (aw_addr >= CAF_OFF_FILT0 && aw_addr <= CAF_OFF_FILT_LAST) begin
                if (aw_addr[2]) begin
                    next_f_eid[fi[3:0]] = caf_merge(f_eid[fi[3:0]], w_data, w_strb, 16'hFFFF);
                end else begin
                    // Unimplemented bits 4 and 2 never store a one
                    next_f_sid[fi[3:0]] = caf_merge(f_sid[fi[3:0]], w_data, w_strb, CAF_SID_WMASK);
                end
            end else if (aw_addr != CAF_OFF_STATUS) begin
                hit = 1'b0;
            end
            next_bresp = hit ? CAF_RESP_OKAY : CAF_RESP_SLVERR;
        end
        next_awready = !next_aw_full && !next_bvalid;
        next_wready = !next_w_full && !next_bvalid;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rd = caf_read(s_axi_araddr);
            next_rvalid = 1'b1;
            next_rdata = {16'h0000, rd[15:0]};
            next_rresp = rd[16] ? CAF_RESP_OKAY : CAF_RESP_SLVERR;
        end
        // One read at a time: arready returns once the data is taken
        next_arready = !next_rvalid;
    end

    // ----------------------------------------------------------------
    // Filter bank
    // ----------------------------------------------------------------
    logic [NUM_FILTERS-1:0] hits;
    logic [CAF_NUM_FILTERS*CAF_MSEL_W-1:0] msel_flat;
    logic [CAF_NUM_FILTERS*CAF_DEST_W-1:0] dest_flat;

    assign msel_flat = {msel[1], msel[0]};
    assign dest_flat = {dest[3], dest[2], dest[1], dest[0]};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FILTERS; gi++) begin : g_filt
            logic [1:0] sel;
            logic [15:0] m_sid;
            logic [15:0] m_eid;
            always_comb begin
                sel = msel_flat[gi*CAF_MSEL_W +: CAF_MSEL_W];
                // No mask compares every bit with the qualifier clear
                if (sel == CAF_MSEL_NONE) begin
                    m_sid = CAF_SID_WMASK & ~(16'h0001 << CAF_TYPE_BIT);
                    m_eid = 16'hFFFF;
                end else begin
                    m_sid = msk_sid[sel];
                    m_eid = msk_eid[sel];
                end
            end
            caf_filter_match u_match (
                .enable(fen[gi]),
                .filt_sid(f_sid[gi]),
                .filt_eid(f_eid[gi]),
                .mask_sid(m_sid),
                .mask_eid(m_eid),
                .msg_sid(msg_sid),
                .msg_eid(msg_eid),
                .msg_ext(msg_ext),
                .hit(hits[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Routing result
    // ----------------------------------------------------------------
    logic next_acc_valid, next_acc_to_fifo, next_rej_valid;
    logic [3:0] next_acc_buffer, next_acc_filter;

    always_comb begin
        logic found;
        logic [3:0] win;
        logic [3:0] dst;
        found = 1'b0;
        win = 4'h0;
        dst = 4'h0;
        // Scan downward so the lowest hit wins
        for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
            if (hits[i]) begin
                found = 1'b1;
                win = 4'(i);
            end
        end
        dst = dest_flat[win*CAF_DEST_W +: CAF_DEST_W];
        next_acc_valid = msg_valid && found;
        next_rej_valid = msg_valid && !found;
        next_acc_filter = found ? win : acc_filter;
        next_acc_to_fifo = (dst == CAF_DEST_FIFO);
        next_acc_buffer = (dst == CAF_DEST_FIFO) ? 4'h0 : dst;
        next_status = status;
        if (msg_valid) begin
            next_status = {found, 2'b00, next_acc_to_fifo, 4'h0, win, next_acc_buffer};
        end
    end

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dest <= '{default: CAF_RST_DEST};
            msel <= '{default: CAF_RST_MSEL};
            fen <= CAF_RST_FEN;
            msk_sid <= '{default: CAF_RST_ID};
            msk_eid <= '{default: CAF_RST_ID};
            f_sid <= '{default: CAF_RST_ID};
            f_eid <= '{default: CAF_RST_ID};
            status <= 16'h0000;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CAF_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= CAF_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            acc_valid <= 1'b0;
            rej_valid <= 1'b0;
            acc_to_fifo <= 1'b0;
            acc_buffer <= 4'h0;
            acc_filter <= 4'h0;
        end else begin
            dest <= next_dest;
            msel <= next_msel;
            fen <= next_fen;
            msk_sid <= next_msk_sid;
            msk_eid <= next_msk_eid;
            f_sid <= next_f_sid;
            f_eid <= next_f_eid;
            status <= next_status;
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            acc_valid <= next_acc_valid;
            rej_valid <= next_rej_valid;
            acc_to_fifo <= next_acc_to_fifo;
            acc_buffer <= next_acc_buffer;
            acc_filter <= next_acc_filter;
        end
    end
endmodule : caf_router
`default_nettype wire

// file: caf_router_properties.sv
// Port-level checks of the acceptance filter router
`default_nettype none
module caf_router_properties
    import caf_pkg::*;
#(
    parameter int NUM_FILTERS = CAF_NUM_FILTERS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [CAF_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic msg_valid,
    input wire logic acc_valid,
    input wire logic acc_to_fifo,
    input wire logic [3:0] acc_buffer,
    input wire logic [3:0] acc_filter,
    input wire logic rej_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    one_answer_a: assert property (msg_valid |=> acc_valid != rej_valid) else $error("no single answer");
    no_spurious_a: assert property (!msg_valid |=> !acc_valid && !rej_valid) else $error("answer without frame");
    fifo_buf_a: assert property (acc_valid && acc_to_fifo |-> acc_buffer == 4'h0)
        else $error("fifo with buffer index");
    buf_range_a: assert property (acc_valid && !acc_to_fifo |-> acc_buffer != CAF_DEST_FIFO)
        else $error("buffer index out of range");
    filt_range_a: assert property (acc_valid |-> acc_filter < NUM_FILTERS)
        else $error("winner out of range");
    sid_gaps_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= CAF_OFF_FILT0
        && s_axi_araddr <= CAF_OFF_FILT_LAST && !s_axi_araddr[2] |=> s_axi_rvalid && s_axi_rdata[4] == 1'b0
        && s_axi_rdata[2] == 1'b0) else $error("unimplemented bit read as one");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper half set");
    bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'hFC |=> s_axi_rvalid
        && s_axi_rresp == CAF_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write response late");
    cover property (acc_valid && acc_to_fifo);
    cover property (rej_valid);
    cover property (s_axi_bvalid && s_axi_bresp == CAF_RESP_SLVERR);
endmodule : caf_router_properties
`default_nettype wire

// file: caf_frame_source.sv
// Model of the protocol engine handing received frame identifiers
`default_nettype none
module caf_frame_source (
    input wire logic ref_clk,
    output logic msg_valid,
    output logic [10:0] msg_sid,
    output logic [17:0] msg_eid,
    output logic msg_ext
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        msg_valid = 1'b0;
        msg_sid = 11'h000;
        msg_eid = 18'h00000;
        msg_ext = 1'b0;
    end
    // One frame for one cycle after an idle gap
    task automatic send(input logic [10:0] s, input logic [17:0] e, input logic x, input int gap);
        repeat (gap + 1) @(posedge ref_clk);
        msg_valid <= 1'b1;
        msg_sid <= s;
        msg_eid <= e;
        msg_ext <= x;
        @(posedge ref_clk);
        // Stale identifier is inverted so no match can ride on it
        msg_valid <= 1'b0;
        msg_sid <= ~s;
        msg_eid <= ~e;
        msg_ext <= ~x;
    endtask : send
endmodule : caf_frame_source
`default_nettype wire

// file: caf_router_tb.sv
// Register and routing tests of the acceptance filter router
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module caf_router_tb
    import caf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, sys_rst;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, acc_buffer, acc_filter;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic msg_valid, msg_ext, acc_valid, acc_to_fifo, rej_valid;
    logic [10:0] msg_sid;
    logic [17:0] msg_eid;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    caf_router dut_u (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .msg_valid,
        .msg_sid, .msg_eid, .msg_ext, .acc_valid, .acc_to_fifo, .acc_buffer, .acc_filter, .rej_valid);
    caf_frame_source src_u (.ref_clk, .msg_valid, .msg_sid, .msg_eid, .msg_ext);
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            finish_test();
        end
    end
    // ----------------------------------------------------------------
    // Bus and frame tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = CAF_RESP_OKAY);
        logic done;
        done = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wvalid <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            // Late ready lets the answer stand one cycle unanswered
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bready <= 1'b0;
                `CHK(s_axi_bresp, er)
                done = 1'b1;
            end else if (s_axi_bvalid) begin
                s_axi_bready <= 1'b1;
            end
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] ed, input logic [1:0] er = CAF_RESP_OKAY);
        logic done;
        done = 1'b0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rready <= 1'b0;
                `CHK(s_axi_rdata, {16'h0000, ed})
                `CHK(s_axi_rresp, er)
                done = 1'b1;
            end else if (s_axi_rvalid) begin
                s_axi_rready <= 1'b1;
            end
        end
    endtask : rd
    task automatic chkm(input logic [10:0] s, input logic [17:0] e, input logic x, input int g,
        input logic a, input logic q, input logic [3:0] b, input logic [3:0] f);
        src_u.send(s, e, x, g);
        #1;
        `CHK(acc_valid, a)
        `CHK(rej_valid, ~a)
        if (a) begin
            `CHK(acc_to_fifo, q)
            `CHK(acc_buffer, b)
            `CHK(acc_filter, f)
        end
    endtask : chkm
    task automatic finish_test();
        $display("Mismatches %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'h3;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(CAF_OFF_DEST0, 16'h0000);
        rd(CAF_OFF_DEST3, 16'h0000);
        rd(CAF_OFF_MSEL1, 16'h0000);
        rd(CAF_OFF_FEN, 16'hFFFF);
        wr(8'h58, 16'hFFFF);
        rd(8'h58, 16'hFFEB);
        wr(8'hBC, 16'hA5C3);
        rd(8'hBC, 16'hA5C3);
        rd(8'hB8, 16'h0000);
        wr(8'hFC, 16'h1234, CAF_RESP_SLVERR);
        rd(8'hFC, 16'h0000, CAF_RESP_SLVERR);
        // Filter 3 alone, unmasked, on identifier 0x123
        wr(CAF_OFF_FEN, 16'h0008);
        wr(CAF_OFF_MSEL1, 16'h00C0);
        wr(8'h58, 16'h2460);
        wr(CAF_OFF_DEST0, 16'hF000);
        chkm(11'h123, '0, 1'b0, 0, 1'b1, 1'b1, 4'h0, 4'h3);
        rd(CAF_OFF_STATUS, 16'h9030);
        chkm(11'h124, '0, 1'b0, 0, 1'b0, 1'b0, 4'h0, 4'h3);
        for (int d = 0; d < 15; d++) begin
            wr(CAF_OFF_DEST0, {4'(d), 12'h000});
            chkm(11'h123, '0, 1'b0, d % 2, 1'b1, 1'b0, 4'(d), 4'h3);
        end
        wr(CAF_OFF_DEST0, 16'hF000);
        wr(8'h58, 16'h246A);
        wr(8'h5C, 16'hBEEF);
        chkm(11'h123, {2'b10, 16'hBEEF}, 1'b1, 0, 1'b1, 1'b1, 4'h0, 4'h3);
        chkm(11'h123, {2'b10, 16'hBEEE}, 1'b1, 0, 1'b0, 1'b0, 4'h0, 4'h3);
        chkm(11'h123, {2'b00, 16'hBEEF}, 1'b1, 0, 1'b0, 1'b0, 4'h0, 4'h3);
        // Mask 0 ignores all, mask 1 qualified, mask 2 SID and EID bits 15-0 (EID bits 17-16 don't care)
        wr(8'h20, 16'h0000);
        wr(8'h30, 16'h0000);
        wr(8'h24, 16'hFFE8);
        wr(8'h34, 16'h0000);
        wr(8'h28, 16'hFFE0);
        wr(8'h38, 16'hFFFF);
        wr(CAF_OFF_MSEL1, 16'h0040);
        chkm(11'h123, '0, 1'b1, 0, 1'b1, 1'b1, 4'h0, 4'h3);
        chkm(11'h123, '0, 1'b0, 0, 1'b0, 1'b0, 4'h0, 4'h3);
        wr(8'h24, 16'hFFC0);
        chkm(11'h122, '0, 1'b0, 0, 1'b1, 1'b1, 4'h0, 4'h3);
        for (int m = 0; m < 4; m++) begin
            wr(CAF_OFF_MSEL1, {8'h00, 2'(m), 6'h00});
            chkm(11'h7FF, '0, 1'b0, 0, 1'(m == 0), 1'b1, 4'h0, 4'h3);
        end
        // Filters 3 and 9 both hit; 9 points at buffer 5
        wr(CAF_OFF_MSEL1, 16'h00C0);
        wr(8'h88, 16'h2460);
        wr(CAF_OFF_MSEL2, 16'h000C);
        wr(8'h08, 16'h0050);
        wr(CAF_OFF_FEN, 16'h0208);
        chkm(11'h123, '0, 1'b0, 0, 1'b1, 1'b1, 4'h0, 4'h3);
        wr(CAF_OFF_FEN, 16'h0200);
        chkm(11'h123, '0, 1'b0, 2, 1'b1, 1'b0, 4'h5, 4'h9);
        rd(CAF_OFF_STATUS, 16'h8095);
        wr(CAF_OFF_FEN, 16'h0000);
        chkm(11'h123, '0, 1'b0, 0, 1'b0, 1'b0, 4'h0, 4'h9);
        finish_test();
    end
endmodule : caf_router_tb
bind caf_router caf_router_properties #(.NUM_FILTERS(NUM_FILTERS)) chk_u (.ref_clk, .sys_rst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .msg_valid,
    .acc_valid, .acc_to_fifo, .acc_buffer, .acc_filter, .rej_valid);
`default_nettype wire
